// [srt_pkg.sv]
// Purpose: Shared constants and types for the seconds rate trimmer
// Assumes: Oscillator pin sampled on core_clk, register word access
// Notes:   Register byte address is four times the register index
// Overview of operation
// - Interval bit clear: correct once per 20 seconds
// - Interval bit set: correct once per 60 seconds
// - Middle trim bits zero disables correction
// - Trim value is a seven-bit signed code
// - Slow crystal: shorten by 128 minus code
// - Fast crystal: correction equals code minus one
// - Codes 0, +1, -64, -63 correct nothing
// - One step near 3 ppm or 1 ppm
// - Raw oscillator output stays untrimmed
// - At most one altered second per window
// - Interval bit on top, trim bits below
// - Power-up flag clears interval and trim bits

package srt_pkg;

	// Oscillator cycles in one nominal second
	localparam int unsigned OSC_HZ        = 32768;
	localparam logic [15:0] SEC_CYCLES    = 16'(OSC_HZ);
	localparam logic [15:0] HALF_SEC      = SEC_CYCLES >> 1;

	// Window lengths in seconds: 20 and 60
	localparam logic [5:0]  WIN_SHORT     = 6'h14;
	localparam logic [5:0]  WIN_LONG      = 6'h3c;

	// Doubling gives two oscillator cycles per step
	localparam int          CORR_SHIFT    = 1;

	// Register map
	localparam int          AXI_AW        = 8;
	localparam logic [5:0]  CTRL_ONE_IDX  = 6'h0e;
	localparam logic [5:0]  TRIM_IDX      = 6'h0f;
	localparam logic [5:0]  STATUS_IDX    = 6'h10;
	localparam logic [7:0]  CTRL_ONE_ADDR = {CTRL_ONE_IDX, 2'b00};
	localparam logic [7:0]  TRIM_ADDR     = {TRIM_IDX, 2'b00};
	localparam logic [7:0]  STATUS_ADDR   = {STATUS_IDX, 2'b00};
	localparam logic [7:0]  CTRL_ONE_RST  = 8'h00;
	localparam logic [7:0]  TRIM_RST      = 8'h00;

	// Trim register fields
	localparam int          TRIM_SEL_BIT  = 7;
	localparam int          TRIM_VAL_MSB  = 6;

	// Control one: pattern 0,0,x,x,0,0,1,1 selects 1 Hz pulse
	localparam logic [7:0]  PULSE_MASK    = 8'hcf;
	localparam logic [7:0]  PULSE_VAL     = 8'h03;

	// Status fields
	localparam int          STAT_POS_MSB  = 5;
	localparam int          STAT_SEL_BIT  = 6;
	localparam int          STAT_PWR_BIT  = 7;
	localparam int          STAT_ACT_BIT  = 8;
	localparam int          STAT_CODE_LSB = 16;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_CTRL = 2'b01,
		SEL_TRIM = 2'b10,
		SEL_STAT = 2'b11
	} srt_sel_e;

	function automatic srt_sel_e srt_decode(input logic [AXI_AW-1:0] addr);
		srt_sel_e sel;
		case ({addr[AXI_AW-1:2], 2'b00})
			CTRL_ONE_ADDR: sel = SEL_CTRL;
			TRIM_ADDR:     sel = SEL_TRIM;
			STATUS_ADDR:   sel = SEL_STAT;
			default:       sel = SEL_NONE;
		endcase
		return sel;
	endfunction : srt_decode

endpackage : srt_pkg

// [srt_sync.sv]
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs change slowly against core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module srt_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : srt_sync

// [srt_tick_gen.sv]
// Purpose: Counts oscillator cycles into trimmed one-second ticks
// Assumes: osc_en pulses once per oscillator cycle
// Notes:   The last second of each window carries the correction
`timescale 1ns/1ps

module srt_tick_gen
	import srt_pkg::*;
#(
	parameter logic [15:0] SEC_LEN = SEC_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       osc_en,
	input  wire logic       interval_sel,
	input  wire logic [6:0] trim_value,
	output logic            sec_tick,
	output logic            first_half,
	output logic [5:0]      window_pos,
	output logic            active_sel,
	output logic [6:0]      active_code
);

	// Follows the parameter, so a shortened test second keeps its half
	localparam logic [15:0] HALF_LEN = SEC_LEN >> 1;

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [5:0]  pos_d;
	logic [5:0]  last_pos;
	logic [7:0]  delta;
	logic [15:0] len;
	logic        sec_end;
	logic        win_end;

	// Signed cycle offset for the corrected second
	function automatic logic [7:0] trim_delta(input logic [6:0] c);
		logic [7:0] corr;
		if (c[5:1] == 5'h00) begin
			corr = 8'h00;
		end else if (c[6]) begin
			corr = {c[6], c};
		end else begin
			corr = {1'b0, c} - 8'h01;
		end
		return corr << CORR_SHIFT;
	endfunction : trim_delta

	assign last_pos = active_sel ? WIN_LONG - 6'h01 : WIN_SHORT - 6'h01;
	assign delta    = trim_delta(active_code);
	// Only the last second of the window is stretched or shrunk
	assign len      = (window_pos == last_pos) ? SEC_LEN + {{8{delta[7]}}, delta}
	                                           : SEC_LEN;
	assign sec_end  = osc_en && (cnt_q == len - 16'h0001);
	assign win_end  = sec_end && (window_pos == last_pos);
	assign cnt_d    = !osc_en ? cnt_q : (sec_end ? 16'h0000 : cnt_q + 16'h0001);
	assign pos_d    = !sec_end ? window_pos : (win_end ? 6'h00 : window_pos + 6'h01);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q       <= 16'h0000;
			window_pos  <= 6'h00;
			sec_tick    <= 1'b0;
			first_half  <= 1'b0;
			active_sel  <= 1'b0;
			active_code <= 7'h00;
		end else begin
			cnt_q      <= cnt_d;
			window_pos <= pos_d;
			sec_tick   <= sec_end;
			first_half <= cnt_d < HALF_LEN;
			// Sampled only at a window boundary, never mid-second
			if (win_end) begin
				active_sel  <= interval_sel;
				active_code <= trim_value;
			end
		end
	end

endmodule : srt_tick_gen

// [srt_top.sv]
// Purpose: Seconds rate trimmer with AXI4-Lite register access
// Assumes: Oscillator and power-up flag arrive as asynchronous pins
// Notes:   One write and one read in flight at most
`timescale 1ns/1ps

module srt_top
	import srt_pkg::*;
#(
	parameter logic [15:0] SEC_LEN = SEC_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              osc_clk_in,
	input  wire logic              power_up_flag,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   raw_osc_output,
	output logic                   sec_tick,
	output logic                   int_pin_o,
	output logic                   int_pin_oe
);

	// Pin synchronisation
	logic [1:0] pins_sync;
	logic       osc_sync;
	logic       pwr_sync;
	logic       pwr_prev_q;
	logic       osc_en;
	logic       pwr_rise;

	// Registers
	logic [7:0] ctrl_one_q;
	logic [7:0] timebase_trim_q;

	// Tick generator state
	logic       first_half;
	logic [5:0] window_pos;
	logic       active_sel;
	logic [6:0] active_code;
	logic       tick_pulse;
	logic       pulse_mode;
	logic       corr_active;
	logic [31:0] status_word;

	// Write channel
	logic              aw_hold_q;
	logic              aw_hold_d;
	logic [AXI_AW-1:0] awaddr_q;
	logic              w_hold_q;
	logic              w_hold_d;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              aw_take;
	logic              w_take;
	logic              wr_do;
	logic              bvalid_d;
	srt_sel_e          wr_sel;
	logic              wr_ctrl;
	logic              wr_trim;

	// Read channel
	logic              ar_take;
	logic              rvalid_d;
	srt_sel_e          rd_sel;
	logic [31:0]       rd_word;

	srt_sync #(
		.W (2)
	) i_srt_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        ({power_up_flag, osc_clk_in}),
		.q        (pins_sync)
	);

	assign osc_sync = pins_sync[0];
	assign pwr_sync = pins_sync[1];

	// The delayed copy doubles as the edge reference and raw output
	assign osc_en   = osc_sync && !raw_osc_output;
	assign pwr_rise = pwr_sync && !pwr_prev_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_osc_output <= 1'b0;
			pwr_prev_q     <= 1'b0;
		end else begin
			raw_osc_output <= osc_sync;
			pwr_prev_q     <= pwr_sync;
		end
	end

	srt_tick_gen #(
		.SEC_LEN (SEC_LEN)
	) i_srt_tick_gen (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.osc_en       (osc_en),
		.interval_sel (timebase_trim_q[TRIM_SEL_BIT]),
		.trim_value   (timebase_trim_q[TRIM_VAL_MSB:0]),
		.sec_tick     (tick_pulse),
		.first_half   (first_half),
		.window_pos   (window_pos),
		.active_sel   (active_sel),
		.active_code  (active_code)
	);

	// Tick is already a flop inside; one more stage keeps outputs aligned
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= tick_pulse;
		end
	end

	// Open-drain pin pulled low for the first half of each second
	assign pulse_mode = (ctrl_one_q & PULSE_MASK) == PULSE_VAL;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_pin_o  <= 1'b0;
			int_pin_oe <= 1'b0;
		end else begin
			int_pin_o  <= 1'b0;
			int_pin_oe <= pulse_mode && first_half;
		end
	end

	// Write address and data are taken independently
	assign aw_take   = s_axi_awvalid && s_axi_awready;
	assign w_take    = s_axi_wvalid && s_axi_wready;
	assign wr_do     = aw_hold_q && w_hold_q;
	assign aw_hold_d = (aw_hold_q || aw_take) && !wr_do;
	assign w_hold_d  = (w_hold_q || w_take) && !wr_do;
	assign bvalid_d  = wr_do || (s_axi_bvalid && !s_axi_bready);
	assign wr_sel    = srt_decode(awaddr_q);
	assign wr_ctrl   = wr_do && (wr_sel == SEL_CTRL) && wstrb_q[0];
	assign wr_trim   = wr_do && (wr_sel == SEL_TRIM) && wstrb_q[0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
		end else begin
			aw_hold_q     <= aw_hold_d;
			w_hold_q      <= w_hold_d;
			s_axi_awready <= !aw_hold_d && !bvalid_d;
			s_axi_wready  <= !w_hold_d && !bvalid_d;
			s_axi_bvalid  <= bvalid_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_q    <= '0;
			wdata_q     <= 32'h0000_0000;
			wstrb_q     <= 4'h0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Power-up clear beats a software write landing in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_one_q      <= CTRL_ONE_RST;
			timebase_trim_q <= TRIM_RST;
		end else if (pwr_rise) begin
			ctrl_one_q      <= CTRL_ONE_RST;
			timebase_trim_q <= TRIM_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_one_q <= wdata_q[7:0];
			end
			// Out-of-range codes are stored as written; software avoids them
			if (wr_trim) begin
				timebase_trim_q <= wdata_q[7:0];
			end
		end
	end

	// Status shows the window actually being counted
	assign corr_active = active_code[5:1] != 5'h00;
	assign status_word = {9'h000,
	                      active_code,
	                      7'h00,
	                      corr_active,
	                      pwr_sync,
	                      active_sel,
	                      window_pos};

	assign ar_take  = s_axi_arvalid && s_axi_arready;
	assign rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);
	assign rd_sel   = srt_decode(s_axi_araddr);

	always_comb begin
		case (rd_sel)
			SEL_CTRL: rd_word = {24'h000000, ctrl_one_q};
			SEL_TRIM: rd_word = {24'h000000, timebase_trim_q};
			SEL_STAT: rd_word = status_word;
			default:  rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (ar_take) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

endmodule : srt_top

// [srt_top_sva.sv]
// Purpose: Port-level checks on the trimmer top
// Assumes: Single core_clk domain, rst_n active low
// Notes:   Bound from the testbench file
`timescale 1ns/1ps

module srt_top_chk
	import srt_pkg::*;
#(
	parameter logic [15:0] SEC_LEN = SEC_CYCLES
) (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        osc_clk_in,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        raw_osc_output,
	input wire logic        sec_tick,
	input wire logic        int_pin_o
);
	logic [1:0] warm_q;

	// Pipeline history is only valid three edges after reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			warm_q <= 2'h0;
		else if (warm_q != 2'h3)
			warm_q <= warm_q + 2'h1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	property p_wr_answer;
		s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	property p_rd_answer;
		s_rd_take |=> s_axi_rvalid;
	endproperty
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_r_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	property p_r_drop;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	property p_raw_follow;
		warm_q == 2'h3 |-> raw_osc_output == $past(osc_clk_in, 3);
	endproperty
	property p_tick_pulse;
		sec_tick |=> !sec_tick;
	endproperty
	property p_int_low;
		!int_pin_o;
	endproperty

	a_wr_answer:  assert property (p_wr_answer) else $error("write answer late");
	a_rd_answer:  assert property (p_rd_answer) else $error("read answer late");
	a_w_block:    assert property (p_w_block) else $error("write ready while busy");
	a_r_block:    assert property (p_r_block) else $error("read ready while busy");
	a_b_drop:     assert property (p_b_drop) else $error("bvalid held after take");
	a_r_drop:     assert property (p_r_drop) else $error("rvalid held after take");
	a_raw_follow: assert property (p_raw_follow) else $error("raw clock altered");
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick too wide");
	a_int_low:    assert property (p_int_low) else $error("pin data not low");
endmodule : srt_top_chk

// [srt_top_tb.sv]
// Purpose: Self-checking bench for the seconds rate trimmer
// Assumes: Oscillator pin period is four core cycles
// Notes:   Short seconds keep the 60 second window affordable
`timescale 1ns/1ps

module srt_top_tb
	import srt_pkg::*;
;
	localparam logic [15:0] SL  = 16'h00f0; // Shortened second must outlast its half
	localparam int          NOM = 960;      // Four core cycles per osc cycle

	logic        core_clk = 1'b0, rst_n = 1'b0, osc_clk_in = 1'b0, power_up_flag = 1'b0;
	logic        osc_ph = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ex;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        raw_osc_output, sec_tick, int_pin_o, int_pin_oe;
	int          bad_count = 0, checked = 0, cnt = 0, hi = 0;
	int          per[$], hp[$];

	srt_top #(.SEC_LEN(SL)) i_srt_top (.*);

	always #25 core_clk = ~core_clk;
	// Pin toggles every second core edge, a four-cycle period
	always @(posedge core_clk) begin
		osc_ph <= ~osc_ph;
		if (osc_ph)
			osc_clk_in <= ~osc_clk_in;
	end

	always @(posedge core_clk) begin
		cnt++;
		if (int_pin_oe === 1'b1)
			hi++;
		if (sec_tick === 1'b1) begin
			per.push_back(cnt);
			hp.push_back(hi);
			cnt = 0;
			hi  = 0;
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(r), "bresp");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e, "rdata");
		chk(32'(s_axi_rresp), 32'(r), "rresp");
	endtask : rd

	task automatic stop_test();
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	initial begin
		repeat (100 * NOM + 4000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(TRIM_ADDR, 32'h0, RESP_OKAY);
		rd(CTRL_ONE_ADDR, 32'h0, RESP_OKAY);
		chk(32'(int_pin_oe), 32'h0, "int_pin_oe");
		rd(8'h00, 32'h0, RESP_SLVERR);
		wr(8'h00, 32'h5a, RESP_SLVERR);
		wr(CTRL_ONE_ADDR, 32'h03, RESP_OKAY);
		wr(TRIM_ADDR, 32'h09, RESP_OKAY);
		rd(TRIM_ADDR, 32'h09, RESP_OKAY);
		rd(CTRL_ONE_ADDR, 32'h03, RESP_OKAY);
		// Second write lands inside window two, so it waits for window three
		while (per.size() < 21)
			@(posedge core_clk);
		wr(TRIM_ADDR, 32'hc6, RESP_OKAY);
		rd(TRIM_ADDR, 32'hc6, RESP_OKAY);
		// Bus stays quiet while the trimmed seconds run
		while (per.size() < 100)
			@(posedge core_clk);
		for (int i = 1; i < 100; i++) begin
			ex = 32'(NOM);
			if (i == 39)
				ex = 32'(NOM + 64);
			if (i == 99)
				ex = 32'(NOM - 464);
			chk(32'(per[i]), ex, "tick period");
			chk(32'(hp[i]), 32'(NOM / 2), "pin drive cycles");
		end
		power_up_flag <= 1'b1;
		repeat (4) @(posedge core_clk);
		power_up_flag <= 1'b0;
		rd(TRIM_ADDR, 32'h0, RESP_OKAY);
		rd(CTRL_ONE_ADDR, 32'h0, RESP_OKAY);
		chk(32'(int_pin_oe), 32'h0, "int_pin_oe");
		// Latched trim survives the clear until the window ends
		rd(STATUS_ADDR, 32'h0046_0140, RESP_OKAY);
		stop_test();
	end
endmodule : srt_top_tb

bind srt_top srt_top_chk #(
	.SEC_LEN (SEC_LEN)
) i_srt_top_chk (
	.core_clk       (core_clk),
	.rst_n          (rst_n),
	.osc_clk_in     (osc_clk_in),
	.s_axi_awvalid  (s_axi_awvalid),
	.s_axi_awready  (s_axi_awready),
	.s_axi_wvalid   (s_axi_wvalid),
	.s_axi_wready   (s_axi_wready),
	.s_axi_bvalid   (s_axi_bvalid),
	.s_axi_bready   (s_axi_bready),
	.s_axi_arvalid  (s_axi_arvalid),
	.s_axi_arready  (s_axi_arready),
	.s_axi_rvalid   (s_axi_rvalid),
	.s_axi_rready   (s_axi_rready),
	.raw_osc_output (raw_osc_output),
	.sec_tick       (sec_tick),
	.int_pin_o      (int_pin_o)
);
